/* core/adc_test_defines.vh */
// named constants for the output test and format register bank
`ifndef ADC_TEST_DEFINES_VH
`define ADC_TEST_DEFINES_VH

// register offsets
`define ADDR_CLOCK_COND 8'h09
`define ADDR_TEST_PATTERN 8'h0D
`define ADDR_OUTPUT_FORMAT 8'h14
`define ADDR_CUSTOM_ONE_LOW 8'h19
`define ADDR_CUSTOM_ONE_HIGH 8'h1A

// reset values
`define RST_CLOCK_COND 8'h01
`define RST_TEST_PATTERN 8'h00
`define RST_OUTPUT_FORMAT 8'h00
`define RST_CUSTOM 8'h00
`define RST_RDATA 8'h00

// value returned for unmapped offsets
`define RDATA_UNMAPPED 8'h00

// writable bit masks (other bits read as zero)
`define MASK_CLOCK_COND 8'h01
`define MASK_TEST_PATTERN 8'hFF
`define MASK_OUTPUT_FORMAT 8'h47

// field positions
`define DCS_BIT 0
`define USER_MODE_HI 7
`define USER_MODE_LO 6
`define PN_LONG_RST_BIT 5
`define PN_SHORT_RST_BIT 4
`define PATTERN_HI 3
`define PATTERN_LO 0
`define LVDS_LP_BIT 6
`define INVERT_BIT 2
`define FORMAT_HI 1
`define FORMAT_LO 0

// user test sequencing codes
`define USER_OFF 2'h0
`define USER_SINGLE_ALT 2'h1
`define USER_SINGLE_ONCE 2'h2
`define USER_ALT_ONCE 2'h3

// output format codes
`define FMT_OFFSET_BIN 2'h0
`define FMT_TWOS_COMP 2'h1

// output test pattern codes
`define PAT_OFF 4'h0
`define PAT_MIDSCALE 4'h1
`define PAT_POS_FS 4'h2
`define PAT_CHECKER 4'h4
`define PAT_PN23 4'h5
`define PAT_PN9 4'h6
`define PAT_WORD_TOGGLE 4'h7
`define PAT_USER 4'h8
`define PAT_BIT_TOGGLE 4'h9
`define PAT_SYNC 4'hA
`define PAT_ONE_HIGH 4'hB
`define PAT_MIXED 4'hC

// pattern words, offset binary, 10 bits
`define WORD_MIDSCALE 10'h200
`define WORD_POS_FS 10'h3FF
`define WORD_ZEROS 10'h000
`define WORD_CHECK_A 10'h155
`define WORD_CHECK_B 10'h2AA
`define WORD_BIT_TOGGLE 10'h2AA
`define WORD_SYNC 10'h01F
`define WORD_ONE_HIGH 10'h200
`define WORD_MIXED_A 10'h0A3
`define WORD_MIXED_B 10'h35C

// pseudorandom generator shapes
`define PN23_WIDTH 23
`define PN23_TAP 18
`define PN9_WIDTH 9
`define PN9_TAP 5

`endif

/* core/lfsr_gen.v */
// fibonacci lfsr with hold-to-seed control, one step per enable
`timescale 1ns/10ps
module lfsr_gen #(
  parameter WIDTH = 9,
  parameter TAP = 5
) (
  input wire clock_in,              // system clock
  input wire srst_in,               // sync reset, active high
  input wire hold_in,               // keep generator at its seed
  input wire step_in,               // advance one position
  output wire [WIDTH-1:0] state_out // current register contents
);
  reg [WIDTH-1:0] lfsr_q;
  reg [WIDTH-1:0] lfsr_d;

  assign state_out = lfsr_q;

  always @* begin
    lfsr_d = lfsr_q;
    if (hold_in) begin
      lfsr_d = {WIDTH{1'b1}};
    end else if (step_in) begin
      lfsr_d = {lfsr_q[WIDTH-2:0], lfsr_q[WIDTH-1] ^ lfsr_q[TAP-1]};
    end
  end

  // all-ones seed: an all-zero state would lock the sequence
  always @(posedge clock_in) begin
    if (srst_in) begin
      lfsr_q <= {WIDTH{1'b1}};
    end else begin
      lfsr_q <= lfsr_d;
    end
  end
endmodule

/* core/adc_output_test_config.v */
// output test, format and clock configuration bank of a quad converter
//
// Overview of operation
// - user sequencing field: off, single alternate, single once, alternate once
// - pattern code 0000, the reset value, passes converted data
// - 0001 drives midscale word, 0010 drives positive full-scale word
// - 0101 drives long pseudorandom sequence, 0110 the short one
// - 0111 alternates all-ones/all-zeros words, 1001 toggles bits
// - 0100 checker, 1000 user word, 1010 sync, 1011 one high, 1100 mixed
// - every test pattern follows the selected number format
// - format field, invert bit, low-power signalling bit; all reset zero
// - user word comes from separate low and high byte registers
`timescale 1ns/10ps
`include "adc_test_defines.vh"
module adc_output_test_config #(
  parameter CHANNELS = 4,
  parameter BITS = 10
) (
  input wire clock_in,                        // 20 MHz clock
  input wire srst_in,                         // sync reset, active high
  input wire reg_wr_in,                       // register write strobe
  input wire reg_rd_in,                       // register read strobe
  input wire [7:0] reg_addr_in,               // register offset
  input wire [7:0] reg_wdata_in,              // write data
  output reg [7:0] reg_rdata_out,             // read data, next cycle
  input wire sample_valid_in,                 // one-cycle sample pulse
  input wire [CHANNELS*BITS-1:0] adc_data_in, // converted words, ch0 low
  output reg [CHANNELS*BITS-1:0] data_out,    // formatted output words
  output reg data_valid_out,                  // data_out updated
  output wire dcs_enable_out,                 // duty cycle stabilizer on
  output wire lvds_low_power_out,             // reduced swing signalling
  output wire test_active_out                 // test data replaces data
);
  // ************************************************************
  // register file
  // ************************************************************
  reg [7:0] clock_conditioning_control_q;
  reg [7:0] test_pattern_control_q;
  reg [7:0] output_format_control_q;
  reg [7:0] custom_word_one_low_q;
  reg [7:0] custom_word_one_high_q;
  reg [7:0] rdata_d;
  wire test_write;

  assign test_write = reg_wr_in && (reg_addr_in == `ADDR_TEST_PATTERN);

  always @(posedge clock_in) begin
    if (srst_in) begin
      clock_conditioning_control_q <= `RST_CLOCK_COND;
      test_pattern_control_q <= `RST_TEST_PATTERN;
      output_format_control_q <= `RST_OUTPUT_FORMAT;
      custom_word_one_low_q <= `RST_CUSTOM;
      custom_word_one_high_q <= `RST_CUSTOM;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `ADDR_CLOCK_COND: begin
          clock_conditioning_control_q <= reg_wdata_in & `MASK_CLOCK_COND;
        end
        `ADDR_TEST_PATTERN: begin
          test_pattern_control_q <= reg_wdata_in & `MASK_TEST_PATTERN;
        end
        `ADDR_OUTPUT_FORMAT: begin
          output_format_control_q <= reg_wdata_in & `MASK_OUTPUT_FORMAT;
        end
        `ADDR_CUSTOM_ONE_LOW: begin
          custom_word_one_low_q <= reg_wdata_in;
        end
        `ADDR_CUSTOM_ONE_HIGH: begin
          custom_word_one_high_q <= reg_wdata_in;
        end
        default: begin
        end
      endcase
    end
  end

  always @* begin
    case (reg_addr_in)
      `ADDR_CLOCK_COND: rdata_d = clock_conditioning_control_q;
      `ADDR_TEST_PATTERN: rdata_d = test_pattern_control_q;
      `ADDR_OUTPUT_FORMAT: rdata_d = output_format_control_q;
      `ADDR_CUSTOM_ONE_LOW: rdata_d = custom_word_one_low_q;
      `ADDR_CUSTOM_ONE_HIGH: rdata_d = custom_word_one_high_q;
      default: rdata_d = `RDATA_UNMAPPED;
    endcase
  end

  // read data holds until the next read strobe
  always @(posedge clock_in) begin
    if (srst_in) begin
      reg_rdata_out <= `RST_RDATA;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata_d;
    end
  end

  // ************************************************************
  // decoded controls
  // ************************************************************
  wire [1:0] user_mode;
  wire [3:0] pattern_sel;
  wire [1:0] format_sel;
  wire invert_on;
  wire [15:0] custom_word;
  wire [BITS-1:0] user_word;

  assign user_mode =
    test_pattern_control_q[`USER_MODE_HI:`USER_MODE_LO];
  assign pattern_sel = test_pattern_control_q[`PATTERN_HI:`PATTERN_LO];
  assign format_sel = output_format_control_q[`FORMAT_HI:`FORMAT_LO];
  assign invert_on = output_format_control_q[`INVERT_BIT];
  assign dcs_enable_out = clock_conditioning_control_q[`DCS_BIT];
  assign lvds_low_power_out = output_format_control_q[`LVDS_LP_BIT];
  // the output word is narrower than the pattern; keep its upper bits
  assign custom_word = {custom_word_one_high_q, custom_word_one_low_q};
  assign user_word = custom_word[15:16-BITS];

  // ************************************************************
  // pattern generators
  // ************************************************************
  wire [`PN23_WIDTH-1:0] pn23_state;
  wire [`PN9_WIDTH-1:0] pn9_state;
  wire [BITS-1:0] pn23_word;
  wire [BITS-1:0] pn9_word;
  reg alt_q;

  lfsr_gen #(
    .WIDTH(`PN23_WIDTH),
    .TAP(`PN23_TAP)
  ) pn_long (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .hold_in(test_pattern_control_q[`PN_LONG_RST_BIT]),
    .step_in(sample_valid_in),
    .state_out(pn23_state)
  );

  lfsr_gen #(
    .WIDTH(`PN9_WIDTH),
    .TAP(`PN9_TAP)
  ) pn_short (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .hold_in(test_pattern_control_q[`PN_SHORT_RST_BIT]),
    .step_in(sample_valid_in),
    .state_out(pn9_state)
  );

  assign pn23_word = pn23_state[BITS-1:0];
  // short register is one bit narrower than the word; repeat its lsb
  assign pn9_word = {pn9_state[0], pn9_state};

  // alternation phase for toggling patterns, one flip per sample
  always @(posedge clock_in) begin
    if (srst_in) begin
      alt_q <= 1'b0;
    end else if (sample_valid_in) begin
      alt_q <= ~alt_q;
    end
  end

  // ************************************************************
  // user test sequencing
  // ************************************************************
  localparam SEQ_FIRST = 2'b00;
  localparam SEQ_SECOND = 2'b01;
  localparam SEQ_DONE = 2'b10;

  reg [1:0] seq_q;
  reg [1:0] seq_d;
  reg seq_user;
  reg [BITS-1:0] seq_word;

  always @* begin
    seq_d = seq_q;
    seq_user = 1'b0;
    seq_word = user_word;
    case (user_mode)
      `USER_SINGLE_ALT: begin
        seq_user = 1'b1;
        seq_word = (seq_q == SEQ_SECOND) ? ~user_word : user_word;
        seq_d = (seq_q == SEQ_SECOND) ? SEQ_FIRST : SEQ_SECOND;
      end
      `USER_SINGLE_ONCE: begin
        seq_user = (seq_q == SEQ_FIRST);
        seq_d = SEQ_DONE;
      end
      `USER_ALT_ONCE: begin
        seq_user = (seq_q != SEQ_DONE);
        seq_word = (seq_q == SEQ_SECOND) ? ~user_word : user_word;
        seq_d = (seq_q == SEQ_FIRST) ? SEQ_SECOND : SEQ_DONE;
      end
      default: begin
        seq_d = SEQ_FIRST;
      end
    endcase
  end

  // a write to the test register restarts the one-shot sequences
  always @(posedge clock_in) begin
    if (srst_in || test_write) begin
      seq_q <= SEQ_FIRST;
    end else if (sample_valid_in) begin
      seq_q <= seq_d;
    end
  end

  // ************************************************************
  // built-in pattern select, offset binary
  // ************************************************************
  reg [BITS-1:0] pat_word;
  wire pattern_on;

  always @* begin
    case (pattern_sel)
      `PAT_MIDSCALE: pat_word = `WORD_MIDSCALE;
      `PAT_POS_FS: pat_word = `WORD_POS_FS;
      `PAT_CHECKER: pat_word = alt_q ? `WORD_CHECK_B : `WORD_CHECK_A;
      `PAT_PN23: pat_word = pn23_word;
      `PAT_PN9: pat_word = pn9_word;
      `PAT_WORD_TOGGLE: pat_word = alt_q ? `WORD_ZEROS : `WORD_POS_FS;
      `PAT_USER: pat_word = user_word;
      `PAT_BIT_TOGGLE: pat_word = `WORD_BIT_TOGGLE;
      `PAT_SYNC: pat_word = `WORD_SYNC;
      `PAT_ONE_HIGH: pat_word = `WORD_ONE_HIGH;
      `PAT_MIXED: pat_word = alt_q ? `WORD_MIXED_B : `WORD_MIXED_A;
      default: pat_word = `WORD_ZEROS;
    endcase
  end

  // unlisted codes fall back to converted data like code 0000
  assign pattern_on = (pattern_sel == `PAT_MIDSCALE) ||
    (pattern_sel == `PAT_POS_FS) ||
    ((pattern_sel >= `PAT_CHECKER) && (pattern_sel <= `PAT_MIXED));
  assign test_active_out = seq_user || pattern_on;

  // ************************************************************
  // per-channel select, format and invert
  // ************************************************************
  // one continuous assign per lane slice keeps a single driver per bit
  wire [CHANNELS*BITS-1:0] data_d;
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : lane
      wire [BITS-1:0] raw_word;
      wire [BITS-1:0] fmt_word;
      // user sequencing overrides the built-in pattern
      assign raw_word = seq_user ? seq_word :
        pattern_on ? pat_word : adc_data_in[ch*BITS +: BITS];
      // twos complement is offset binary with the msb flipped
      assign fmt_word = (format_sel == `FMT_TWOS_COMP) ?
        {~raw_word[BITS-1], raw_word[BITS-2:0]} : raw_word;
      assign data_d[ch*BITS +: BITS] = invert_on ? ~fmt_word : fmt_word;
    end
  endgenerate

  always @(posedge clock_in) begin
    if (srst_in) begin
      data_out <= {CHANNELS*BITS{1'b0}};
      data_valid_out <= 1'b0;
    end else begin
      data_valid_out <= sample_valid_in;
      if (sample_valid_in) begin
        data_out <= data_d;
      end
    end
  end
endmodule

/* tb/adc_output_test_config_checker.sv */
// port assertions for the output test and format bank
`timescale 1ns/10ps
module adc_output_test_config_checker #(
  parameter CHANNELS = 4,
  parameter BITS = 10
) (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic sample_valid_in,
  input wire logic [CHANNELS*BITS-1:0] adc_data_in,
  input wire logic [CHANNELS*BITS-1:0] data_out,
  input wire logic data_valid_out,
  input wire logic dcs_enable_out,
  input wire logic lvds_low_power_out,
  input wire logic test_active_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (srst_in);
  // ****************************************
  // write steps
  // ****************************************
  sequence s_clk_wr;
    reg_wr_in && reg_addr_in == 8'h09;
  endsequence
  sequence s_fmt_wr;
    reg_wr_in && reg_addr_in == 8'h14;
  endsequence
  sequence s_pat_wr(v);
    reg_wr_in && reg_addr_in == 8'h0D && reg_wdata_in == v;
  endsequence
  // ****************************************
  // properties
  // ****************************************
  a_valid_pulse: assert property (sample_valid_in |=> data_valid_out)
    else $error("valid missing after sample");
  a_valid_idle: assert property (!sample_valid_in |=> !data_valid_out)
    else $error("valid without sample");
  a_data_hold: assert property (!sample_valid_in |=> $stable(data_out))
    else $error("data changed without sample");
  a_dcs_write: assert property (s_clk_wr |=>
    dcs_enable_out == $past(reg_wdata_in[0])) else $error("dcs not written");
  a_dcs_hold: assert property (!reg_wr_in |=> $stable(dcs_enable_out))
    else $error("dcs moved");
  a_lp_write: assert property (s_fmt_wr |=>
    lvds_low_power_out == $past(reg_wdata_in[6])) else $error("lp not set");
  a_pat_off: assert property (s_pat_wr(8'h00) |=> !test_active_out)
    else $error("test active when off");
  a_pat_on: assert property (s_pat_wr(8'h01) |=> test_active_out)
    else $error("test not active");
  a_rdata_hold: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data moved");
endmodule

/* tb/tb_adc_output_test_config.sv */
// self-checking bench for the output test and format bank
`timescale 1ns/10ps
`include "adc_test_defines.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  $display("BAD %s exp %h got %h", n, e, g); fail_count++; end end
module tb_adc_output_test_config;
  logic clock_in = 0;
  logic srst_in = 1;
  logic reg_wr_in = 0;
  logic reg_rd_in = 0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic sample_valid_in = 0;
  logic [39:0] adc_data_in = 40'h0;
  wire [7:0] reg_rdata_out;
  wire [39:0] data_out;
  wire data_valid_out, dcs_enable_out, lvds_low_power_out, test_active_out;
  int fail_count = 0;
  int num_checks = 0;
  logic [9:0] w, v;
  logic [7:0] codes [4] = '{8'h04, 8'h0A, 8'h0B, 8'h0C};
  logic [9:0] ea [4] = '{10'h155, 10'h01F, 10'h200, 10'h0A3};
  logic [9:0] eb [4] = '{10'h2AA, 10'h01F, 10'h200, 10'h35C};
  adc_output_test_config uut (.clock_in(clock_in), .srst_in(srst_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .sample_valid_in(sample_valid_in),
    .adc_data_in(adc_data_in), .data_out(data_out),
    .data_valid_out(data_valid_out), .dcs_enable_out(dcs_enable_out),
    .lvds_low_power_out(lvds_low_power_out),
    .test_active_out(test_active_out));
  always #25 clock_in = ~clock_in;
  // ****************************************
  // bus and sample tasks
  // ****************************************
  task report_and_stop;
    if (fail_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clock_in) #1;
    reg_wr_in = 1;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(posedge clock_in) #1;
    reg_wr_in = 0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(posedge clock_in) #1;
    reg_rd_in = 1;
    reg_addr_in = a;
    @(posedge clock_in) #1;
    reg_rd_in = 0;
    `CHK("rdata", e, reg_rdata_out)
  endtask
  // one sample on all four lanes; lanes must agree
  task smp(input [9:0] d, output [9:0] g);
    @(posedge clock_in) #1;
    sample_valid_in = 1;
    adc_data_in = {4{d}};
    @(posedge clock_in) #1;
    sample_valid_in = 0;
    g = data_out[39:30];
    `CHK("valid", 1'b1, data_valid_out)
    `CHK("lanes", {4{g}}, data_out)
  endtask
  task expw(input [9:0] d, input [9:0] e);
    smp(d, w);
    `CHK("word", e, w)
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_reset;
    rd(`ADDR_CLOCK_COND, 8'h01);
    rd(`ADDR_TEST_PATTERN, 8'h00);
    rd(`ADDR_OUTPUT_FORMAT, 8'h00);
    rd(8'h55, 8'h00);
    `CHK("lp", 1'b0, lvds_low_power_out)
    `CHK("active", 1'b0, test_active_out)
    expw(10'h123, 10'h123);
  endtask
  task t_fixed;
    wr(`ADDR_TEST_PATTERN, 8'h01);
    `CHK("active", 1'b1, test_active_out)
    expw(10'h123, 10'h200);
    wr(`ADDR_TEST_PATTERN, 8'h02);
    expw(10'h123, 10'h3FF);
    wr(`ADDR_OUTPUT_FORMAT, 8'h01);
    expw(10'h123, 10'h1FF);
    wr(`ADDR_OUTPUT_FORMAT, 8'h05);
    expw(10'h123, 10'h200);
    wr(`ADDR_OUTPUT_FORMAT, 8'h40);
    rd(`ADDR_OUTPUT_FORMAT, 8'h40);
    `CHK("lp", 1'b1, lvds_low_power_out)
    wr(`ADDR_OUTPUT_FORMAT, 8'h00);
  endtask
  task t_toggle;
    wr(`ADDR_TEST_PATTERN, 8'h07);
    smp(10'h0, v);
    smp(10'h0, w);
    `CHK("toggle", ~v, w)
    `CHK("ends", 1'b1, v == 10'h3FF || v == 10'h000)
    wr(`ADDR_TEST_PATTERN, 8'h09);
    expw(10'h0, 10'h2AA);
    // alternating codes may sit on either phase
    for (int i = 0; i < 4; i++) begin
      wr(`ADDR_TEST_PATTERN, codes[i]);
      smp(10'h0, w);
      `CHK("pattern", 1'b1, w === ea[i] || w === eb[i])
    end
  endtask
  task t_user;
    wr(`ADDR_CUSTOM_ONE_LOW, 8'hC0);
    wr(`ADDR_CUSTOM_ONE_HIGH, 8'h5A);
    wr(`ADDR_TEST_PATTERN, 8'h08);
    expw(10'h0F0, 10'h16B);
    wr(`ADDR_TEST_PATTERN, 8'h80);
    expw(10'h0F0, 10'h16B);
    expw(10'h0F0, 10'h0F0);
    wr(`ADDR_TEST_PATTERN, 8'hC0);
    expw(10'h0F0, 10'h16B);
    expw(10'h0F0, 10'h294);
    expw(10'h0F0, 10'h0F0);
    wr(`ADDR_TEST_PATTERN, 8'h40);
    expw(10'h0F0, 10'h16B);
    expw(10'h0F0, 10'h294);
    expw(10'h0F0, 10'h16B);
  endtask
  task t_pn;
    wr(`ADDR_TEST_PATTERN, 8'h16);
    expw(10'h0, 10'h3FF);
    expw(10'h0, 10'h3FF);
    wr(`ADDR_TEST_PATTERN, 8'h25);
    expw(10'h0, 10'h3FF);
    // released from its seed, the long generator shifts in a zero first
    wr(`ADDR_TEST_PATTERN, 8'h05);
    expw(10'h0, 10'h3FF);
    expw(10'h0, 10'h3FE);
    wr(`ADDR_TEST_PATTERN, 8'h06);
    smp(10'h0, v);
    smp(10'h0, w);
    `CHK("pn runs", 1'b1, v !== w)
    wr(`ADDR_TEST_PATTERN, 8'h00);
    expw(10'h321, 10'h321);
    wr(`ADDR_CLOCK_COND, 8'hFE);
    `CHK("dcs", 1'b0, dcs_enable_out)
    wr(`ADDR_CLOCK_COND, 8'hFF);
    rd(`ADDR_CLOCK_COND, 8'h01);
  endtask
  initial begin
    repeat (10) @(posedge clock_in);
    #1;
    srst_in = 0;
    t_reset();
    t_fixed();
    t_toggle();
    t_user();
    t_pn();
    report_and_stop();
  end
  // the whole run needs well under 400 cycles
  initial begin
    #100000;
    fail_count++;
    report_and_stop();
  end
endmodule
bind adc_output_test_config adc_output_test_config_checker #(
  .CHANNELS(CHANNELS), .BITS(BITS)) chk (.clock_in(clock_in),
  .srst_in(srst_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out), .sample_valid_in(sample_valid_in),
  .adc_data_in(adc_data_in), .data_out(data_out),
  .data_valid_out(data_valid_out), .dcs_enable_out(dcs_enable_out),
  .lvds_low_power_out(lvds_low_power_out),
  .test_active_out(test_active_out));
